// file: relay_spi_pkg.sv
// Constants, types and decode helpers for the relay driver serial control.
// Assumes a single system clock domain plus the serial clock domain.
package relay_spi_pkg;

  localparam int         CH_NUM     = 4;
  localparam int         FRAME_BITS = 8;
  localparam int         CNT_W      = 3;
  localparam int         MODE_W     = 2;
  localparam int         SYNC_W     = 12;
  localparam int         OL_BIT     = 1;
  localparam int         FAULT_BIT  = 0;
  localparam int         TER_BIT    = 8;
  localparam logic [2:0] CNT_ZERO   = 3'h0;
  localparam logic [2:0] CNT_ONE    = 3'h1;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [8:0] DIAG_RST   = 9'h100;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_DIRECT  = 2'b01,
    MODE_ON      = 2'b10,
    MODE_OFF     = 2'b11
  } chan_mode_t;

  typedef struct packed {
    logic open_load_flag;
    logic channel_fault_flag;
  } chan_diag_t;

  typedef struct packed {
    logic                    transfer_error_flag;
    chan_diag_t [CH_NUM-1:0] ch;
  } diagnosis_flags_t;

  typedef struct packed {
    logic [CH_NUM-1:0] chan_in;
    logic [CH_NUM-1:0] open_load_det;
    logic [CH_NUM-1:0] overload_det;
  } analog_in_t;

  // Channel switch state for a mode and its input pin
  function automatic logic chan_on(input chan_mode_t m, input logic pin);
    case (m)
      MODE_DIRECT: chan_on = pin;
      MODE_ON:     chan_on = 1'b1;
      default:     chan_on = 1'b0;
    endcase
  endfunction : chan_on

  // Pull-down diagnosis current enable
  function automatic logic chan_cur(input chan_mode_t m, input logic pin);
    case (m)
      MODE_STANDBY: chan_cur = 1'b0;
      MODE_DIRECT:  chan_cur = ~pin;
      default:      chan_cur = 1'b1;
    endcase
  endfunction : chan_cur

endpackage : relay_spi_pkg

// file: bit_sync.sv
// Two-stage synchroniser for levels entering the system clock domain.
// Assumes the reset given is already released synchronously.
`timescale 1ns/10ps
module bit_sync
  import relay_spi_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : bit_sync

// file: relay_spi_ctrl.sv
// Serial control and diagnosis logic of a four-channel low-side driver.
// Assumes the master keeps SCLK low across select edges and leaves
// at least a few system clocks between the last SCLK edge and CS_N rising.
// The falling-edge serial clock logic takes its resets from the system domain.
`timescale 1ns/10ps
module relay_spi_ctrl
  import relay_spi_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              SCLK,
  input  wire logic              CS_N,
  input  wire logic              SI,
  output logic                   SO,
  output logic                   SO_OE,
  input  wire logic [CH_NUM-1:0] CH_IN,
  input  wire logic [CH_NUM-1:0] OPEN_LOAD_DET,
  input  wire logic [CH_NUM-1:0] OVERLOAD_DET,
  output logic      [CH_NUM-1:0] CH_ON,
  output logic      [CH_NUM-1:0] DIAG_CUR_EN
);

  // System domain reset and synchronised pins
  logic                    rst_meta_ff;
  logic                    rst_n;
  logic                    cs_n_sync;
  logic                    cs_n_q_ff;
  logic                    cs_fall;
  logic                    cs_rise;
  analog_in_t              pins_raw;
  analog_in_t              pins;

  // Frame tracking and registers
  logic                    link_clr_ff;
  logic                    nxt_link_clr;
  logic                    link_rst;
  logic                    commit_ff;
  logic                    frame_ok_ff;
  logic [FRAME_BITS-1:0]   frame_data_ff;
  diagnosis_flags_t        snap_ff;
  diagnosis_flags_t        diag_now;
  logic                    ter_ff;
  logic [7:0]              mode_ff;
  logic                    commit_ok;

  // Drive state and diagnosis flags per channel
  logic [CH_NUM-1:0]       ol_ff;
  logic [CH_NUM-1:0]       flt_ff;
  logic [CH_NUM-1:0]       ch_on_ff;
  logic [CH_NUM-1:0]       cur_ff;

  // Serial clock domain, falling edge
  logic [FRAME_BITS-1:0]   shift_ff;
  logic [FRAME_BITS-1:0]   nxt_shift;
  logic [CNT_W-1:0]        bit_cnt_ff;
  logic [CNT_W-1:0]        nxt_bit_cnt;
  logic                    byte_done_ff;
  logic                    nxt_byte_done;
  logic                    started_ff;
  logic                    first_fall;

  // Serial clock domain, rising edge
  logic                    rise_seen_ff;
  logic                    so_ff;
  logic                    link_idle;

  // Reset release
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  bit_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (CS_N),
    .q     (cs_n_sync)
  );

  assign pins_raw.chan_in       = CH_IN;
  assign pins_raw.open_load_det = OPEN_LOAD_DET;
  assign pins_raw.overload_det  = OVERLOAD_DET;

  bit_sync #(
    .W       (SYNC_W),
    .RST_VAL (12'h000)
  ) u_pin_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins)
  );

  // Select edge detection on the synchronised copy
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      cs_n_q_ff <= 1'b1;
    else
      cs_n_q_ff <= cs_n_sync;
  end

  assign cs_fall = cs_n_q_ff & ~cs_n_sync;
  assign cs_rise = ~cs_n_q_ff & cs_n_sync;

  // Link counters stay cleared from the commit until the next access
  // opens; a clockless access then leaves no stale count behind
  always_comb
  begin
    if (cs_rise)
      nxt_link_clr = 1'b1;
    else if (cs_fall)
      nxt_link_clr = 1'b0;
    else
      nxt_link_clr = link_clr_ff;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      link_clr_ff <= 1'b1;
    else
      link_clr_ff <= nxt_link_clr;
  end

  // Both terms are flop outputs and the clear is set during reset
  assign link_rst = link_clr_ff | ~rst_n;

  // Current flags as the diagnosis word
  always_comb
  begin
    diag_now.transfer_error_flag = ter_ff;
    for (int i = 0; i < CH_NUM; i++)
    begin
      diag_now.ch[i].open_load_flag     = ol_ff[i];
      diag_now.ch[i].channel_fault_flag = flt_ff[i];
    end
  end

  // Snapshot is stable long before the first SCLK rise, so the link
  // domain may read it as a quasi-static word
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      snap_ff <= DIAG_RST;
    else if (cs_fall)
      snap_ff <= diag_now;
  end

  // A frame counts only when it saw clocks and ended on a byte boundary
  function automatic logic frame_whole(input logic             seen,
                                       input logic [CNT_W-1:0] cnt,
                                       input logic             done);
    frame_whole = seen && (cnt == CNT_ZERO) && done;
  endfunction : frame_whole

  // Link counters are idle by the time the synced rise is seen, and
  // they are read only at that one edge, so no word crosses mid-shift
  assign commit_ok = frame_whole(started_ff, bit_cnt_ff, byte_done_ff);

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      commit_ff     <= 1'b0;
      frame_ok_ff   <= 1'b0;
      frame_data_ff <= MODE_RST;
    end
    else
    begin
      commit_ff <= cs_rise;
      // Captured before the clear reaches the link counters
      if (cs_rise)
      begin
        frame_ok_ff   <= commit_ok;
        frame_data_ff <= shift_ff;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      ter_ff <= 1'b1;
    else if (commit_ff)
      ter_ff <= ~frame_ok_ff;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= MODE_RST;
    else if (commit_ff && frame_ok_ff)
      mode_ff <= frame_data_ff;
  end

  // Per-channel drive and diagnosis
  genvar g;
  generate
    for (g = 0; g < CH_NUM; g++)
    begin : g_ch
      chan_mode_t m;
      logic       on_now;

      assign m      = chan_mode_t'(mode_ff[g*MODE_W +: MODE_W]);
      assign on_now = chan_on(m, pins.chan_in[g]);

      always_ff @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          ch_on_ff[g] <= 1'b0;
        else
          ch_on_ff[g] <= on_now;
      end

      // Pin-following current is cut while the channel conducts
      always_ff @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          cur_ff[g] <= 1'b0;
        else
          cur_ff[g] <= chan_cur(m, pins.chan_in[g]);
      end

      // Sticky open-load flag; a detection beats the stand-by clear
      always_ff @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          ol_ff[g] <= 1'b0;
        else if (pins.open_load_det[g] && !ch_on_ff[g] && cur_ff[g])
          ol_ff[g] <= 1'b1;
        else if (m == MODE_STANDBY)
          ol_ff[g] <= 1'b0;
      end

      // Sticky fault flag for an overload detected while on
      always_ff @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          flt_ff[g] <= 1'b0;
        else if (pins.overload_det[g] && ch_on_ff[g])
          flt_ff[g] <= 1'b1;
        else if (m == MODE_STANDBY)
          flt_ff[g] <= 1'b0;
      end
    end
  endgenerate

  assign CH_ON       = ch_on_ff;
  assign DIAG_CUR_EN = cur_ff;

  // Falling SCLK: capture SI. The first edge after the clear loads the
  // snapshot, so the flags leave ahead of the pass-through bits.
  assign first_fall = ~started_ff;

  always_comb
  begin
    if (first_fall)
    begin
      nxt_shift     = {snap_ff[FRAME_BITS-2:0], SI};
      nxt_bit_cnt   = CNT_ONE;
      nxt_byte_done = 1'b0;
    end
    else
    begin
      nxt_shift     = {shift_ff[FRAME_BITS-2:0], SI};
      nxt_bit_cnt   = bit_cnt_ff + CNT_ONE;
      nxt_byte_done = byte_done_ff | (bit_cnt_ff == 3'h7);
    end
  end

  // Gated by the select level, steady around edges by the master's timing
  always_ff @(negedge SCLK or negedge rst_n)
  begin
    if (!rst_n)
      shift_ff <= MODE_RST;
    else if (!CS_N)
      shift_ff <= nxt_shift;
  end

  // Counts restart only through the clear, which lifts at the synced
  // select fall well before the first serial clock edge
  always_ff @(negedge SCLK or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt_ff   <= CNT_ZERO;
      byte_done_ff <= 1'b0;
      started_ff   <= 1'b0;
    end
    else if (!CS_N)
    begin
      bit_cnt_ff   <= nxt_bit_cnt;
      byte_done_ff <= nxt_byte_done;
      started_ff   <= 1'b1;
    end
  end

  // Deselect or reset clears the output stage asynchronously
  assign link_idle = CS_N | ~rst_n;

  always_ff @(posedge SCLK or posedge link_idle)
  begin
    if (link_idle)
    begin
      rise_seen_ff <= 1'b0;
      so_ff        <= 1'b0;
    end
    else
    begin
      rise_seen_ff <= 1'b1;
      // First rise shows diagnosis bit 7, the channel 3 open-load flag, later ones the shifter
      so_ff <= rise_seen_ff ? shift_ff[FRAME_BITS-1]
                            : snap_ff[FRAME_BITS-1];
    end
  end

  // Before the first rise the error flag is ORed with SI so a fault
  // anywhere in a chain reaches the master. The live flag is used, as
  // the snapshot lands a few system clocks after the select falls.
  always_comb
  begin
    if (CS_N)
      SO = 1'b0;
    else if (!rise_seen_ff)
      SO = ter_ff | SI;
    else
      SO = so_ff;
  end

  // Enable is the select level alone, so deselect floats the line at once
  assign SO_OE = ~CS_N;

endmodule : relay_spi_ctrl

// file: relay_spi_ctrl_props.sv
// Port checker for the relay serial control.
// Assumes bind onto relay_spi_ctrl; SCLK low across CS_N edges.
`timescale 1ns/10ps
module relay_spi_ctrl_props
  import relay_spi_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              SCLK,
  input wire logic              CS_N,
  input wire logic              SI,
  input wire logic              SO,
  input wire logic              SO_OE,
  input wire logic [CH_NUM-1:0] CH_IN,
  input wire logic [CH_NUM-1:0] CH_ON,
  input wire logic [CH_NUM-1:0] DIAG_CUR_EN
);
  logic       first_ff;
  logic       rose_ff;
  logic [7:0] hist_ff;
  logic [4:0] cnt_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN) first_ff <= 1'b1;
    else if ($rose(CS_N)) first_ff <= 1'b0;
  always_ff @(posedge SCLK or posedge CS_N)
    if (CS_N) rose_ff <= 1'b0;
    else rose_ff <= 1'b1;
  // Saturates so long chains never wrap
  always_ff @(negedge SCLK or posedge CS_N)
    if (CS_N) cnt_ff <= 5'h00;
    else if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
  always_ff @(negedge SCLK)
    hist_ff <= {hist_ff[6:0], SI};
  sequence s_quiet;
    (!CS_N && $stable(CH_IN)) [*6];
  endsequence
  a_oe_tracks_cs:
    assert property (SO_OE == !CS_N) else $error("oe wrong");
  a_so_idle_low:
    assert property (CS_N |-> !SO) else $error("so not parked");
  a_err_or_input:
    assert property (!CS_N && !rose_ff && SI |-> SO) else $error("so low");
  a_reset_flags_err:
    assert property (!CS_N && !rose_ff && first_ff |-> SO)
      else $error("no error after reset");
  a_so_rise_only:
    assert property (!CS_N && !$past(CS_N) && !$rose(SCLK) && $stable(SI)
      |-> $stable(SO)) else $error("so moved off rise");
  a_no_commit_busy:
    assert property (s_quiet |=> $stable({CH_ON, DIAG_CUR_EN}))
      else $error("outputs moved in access");
  a_reset_clears:
    assert property (disable iff (1'b0)
      !RESETN |-> CH_ON == 4'h0 && DIAG_CUR_EN == 4'h0)
      else $error("outputs not cleared");
  a_chain_pass:
    assert property (@(negedge SCLK) disable iff (CS_N || !RESETN)
      cnt_ff >= 5'h08 |-> SO == hist_ff[7]) else $error("no pass-through");
endmodule : relay_spi_ctrl_props
bind relay_spi_ctrl relay_spi_ctrl_props chk (.*);

// file: spi_master_model.sv
// Serial master: frames accesses, drives clock and data.
// Assumes caller spaces frames; clock stands low outside frames.
`timescale 1ns/10ps
module spi_master_model
(
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  int   half = 24;
  logic last = 1'b0;
  logic mi;
  // Released line shows the inverse, never a stale match
  always @(so or so_oe)
    if (so_oe) last = so;
  assign mi = so_oe ? so : ~last;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task automatic xfer(input int n, input logic [15:0] d,
                      output logic pre, output logic [15:0] q);
    q = 16'h0000;
    #1.3;
    si = (n > 0) ? d[n-1] : 1'b0;
    cs_n = 1'b0;
    #260 pre = mi;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = d[i];
      sclk = 1'b1;
      #(half) sclk = 1'b0;
      q = {q[14:0], mi};
      #(half);
    end
    #236 cs_n = 1'b1;
    #260;
  endtask : xfer
endmodule : spi_master_model

// file: test_relay_spi_ctrl.sv
// Self-checking bench for relay_spi_ctrl driven by a serial master.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module test_relay_spi_ctrl;
  logic        clk;
  logic        resetn;
  logic        sclk, cs_n, si, so, so_oe;
  logic [3:0]  ch_in, ol, ov, ch_on, cur;
  logic        pre;
  logic [15:0] q;
  int          miscompares = 0;
  int          samples_checked = 0;
  relay_spi_ctrl dut (.CLK(clk), .RESETN(resetn), .SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .CH_IN(ch_in),
    .OPEN_LOAD_DET(ol), .OVERLOAD_DET(ov), .CH_ON(ch_on),
    .DIAG_CUR_EN(cur));
  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic acc(input int n, input logic [15:0] d, input logic ep,
                     input logic [15:0] eq, input logic [7:0] eo);
    m.xfer(n, d, pre, q);
    chk({15'h0000, pre}, ep);
    chk(q, eq);
    repeat (12) @(posedge clk);
    chk({8'h00, ch_on, cur}, {8'h00, eo});
  endtask : acc
  initial
  begin
    #300000;
    miscompares++;
    final_report();
  end
  initial
  begin
    resetn <= 1'b0;
    ch_in <= 4'h4;
    ol <= 4'h0;
    ov <= 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    acc(8, 16'h009C, 1'b1, 16'h0000, 8'hCA);
    ch_in <= 4'h0;
    repeat (12) @(posedge clk);
    chk({8'h00, ch_on, cur}, 16'h008E);
    ol <= 4'hF;
    ov <= 4'hF;
    repeat (8) @(posedge clk);
    ol <= 4'h0;
    ov <= 4'h0;
    acc(8, 16'h001C, 1'b0, 16'h0068, 8'h06);
    acc(7, 16'h003F, 1'b0, 16'h0014, 8'h06);
    acc(0, 16'h0000, 1'b1, 16'h0000, 8'h06);
    acc(16, 16'h00AA, 1'b1, 16'h2800, 8'hFF);
    m.half = 100;
    acc(8, 16'h0055, 1'b0, 16'h0028, 8'h0F);
    m.half = 24;
    acc(8, 16'h00C0, 1'b1, 16'h0028, 8'h08);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    chk({8'h00, ch_on, cur}, 16'h0000);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    acc(8, 16'h0000, 1'b1, 16'h0000, 8'h00);
    final_report();
  end
endmodule : test_relay_spi_ctrl
